/* ocs_delay_line.sv */
// Purpose: Fixed-length shift delay for clock phase samples
// Assumes: One clock
// Notes: Tap selects output delay, output registered
`timescale 1ns/1ps
module ocs_delay_line (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Data
	input wire logic din,
	input wire logic [3:0] tap,
	output logic dout
);
	logic [7:0] stage;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stage <= 8'hFF;
		end else begin
			stage <= {stage[6:0], din};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dout <= 1'b1;
		end else begin
			dout <= stage[tap[2:0]];
		end
	end
endmodule : ocs_delay_line

/* ocs_map.svh */
// Purpose: Offsets, field positions, reset values and timing counts for output clock sync
// Assumes: 32-bit AHB-Lite register words at byte addresses
// Notes: Definitions only
`ifndef OCS_MAP_SVH
`define OCS_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define OCS_ADDR_CTRL 8'h00
`define OCS_ADDR_STATUS 8'h04
`define OCS_ADDR_TAD 8'h08

// ****************************************
// Control fields
// ****************************************
`define OCS_CTRL_DEMUX 0
`define OCS_CTRL_MS_SYNC 1
`define OCS_CTRL_SLAVE 2
`define OCS_CTRL_ECM 3
`define OCS_CTRL_RST_EN 4
`define OCS_CTRL_PHASE 5
`define OCS_CTRL_RESET 6'h00

// ****************************************
// Status fields
// ****************************************
`define OCS_STAT_PHASE_LO 0
`define OCS_STAT_HELD 2
`define OCS_STAT_ARMED 3
`define OCS_STAT_LOCKED 4
`define OCS_STAT_PULSES_LO 8

// ****************************************
// Timing counts in input clock cycles
// ****************************************
`define OCS_DIV_LAST 2'h3
`define OCS_SYNC_DLY_90 4'h4
`define OCS_SYNC_DLY_0 4'h5
`define OCS_PIPE_LAT 4'h3
`define OCS_OUT_DLY 4'h2
`define OCS_TAD_RESET 2'h0

`endif

/* ocs_output_clock_sync.sv */
// Behaviour
// - I and Q output clocks always share one source and stay in phase.
// - Demux mode output clock is input clock divided by four.
// - Slave selects its divider phase from the master's reference clock.
// - Master/slave alignment tracked every cycle, fixed by next output clock.
// - Each device drives reference outputs so slaves may chain as tree.
// - Master/slave sync is enabled only by control register bits.
// - Output clock reset needs extended control mode, disabled after reset.
// - Output clock leaves after fixed latency; in demux mode also shifted by aperture delay.
// - Output clock reset input accepted asynchronously in run and wait states; ignored during resume.
// - Held high during reset in demux mode; toggles in non-demux.
// - A narrow pulse may appear before the hold takes effect.
// - After release, fixed delay then next edge aligns the output clock.
// - Phase select high: sync edge four cycles after first edge.
// - Phase select low: sync edge five cycles after first edge.
// - Output clock resumes after a constant output delay.
// - First pulse after power-on may exit loosely; later ones deterministic.
//
// Purpose: Output data clock divider with master/slave and reset-pulse sync
// Assumes: hclk stands for the sampling input clock; AHB-Lite slave, OKAY only
// Notes: Zero wait states on the bus
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module ocs_output_clock_sync
	import ocs_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Sync pins
	input wire logic output_clock_reset,
	input wire logic sync_reference_in,
	// Output clocks
	output logic i_channel_output_clock,
	output logic q_channel_output_clock,
	output logic sync_reference_out_a,
	output logic sync_reference_out_b
);
`include "ocs_map.svh"

	// ****************************************
	// Bus slave
	// ****************************************
	logic wr_pend;
	logic [7:0] wr_addr;
	logic [5:0] ctrl;
	logic [1:0] tad;
	logic [1:0] phase;
	logic locked;
	logic armed;
	logic [7:0] pulses;
	ocs_state_type state;

	function automatic logic is_addr(input logic [7:0] a, input logic [7:0] target);
		is_addr = (a == target);
	endfunction : is_addr

	wire logic take = hsel && hready && htrans[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= take && hwrite;
			wr_addr <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= `OCS_CTRL_RESET;
			tad <= `OCS_TAD_RESET;
		end else if (wr_pend) begin
			if (is_addr(wr_addr, `OCS_ADDR_CTRL)) begin
				ctrl <= hwdata[5:0];
			end
			if (is_addr(wr_addr, `OCS_ADDR_TAD)) begin
				tad <= hwdata[1:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			if (is_addr(haddr[7:0], `OCS_ADDR_CTRL)) begin
				hrdata <= {26'h000_0000, ctrl};
			end else if (is_addr(haddr[7:0], `OCS_ADDR_STATUS)) begin
				hrdata <= {16'h0000, pulses, 3'h0, locked, armed, state == OCS_HOLD, phase};
			end else if (is_addr(haddr[7:0], `OCS_ADDR_TAD)) begin
				hrdata <= {30'h0000_0000, tad};
			end else begin
				hrdata <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	wire logic demux = ctrl[`OCS_CTRL_DEMUX];
	wire logic ms_sync = ctrl[`OCS_CTRL_MS_SYNC];
	wire logic is_slave = ctrl[`OCS_CTRL_SLAVE];
	wire logic rst_on = ctrl[`OCS_CTRL_ECM] && ctrl[`OCS_CTRL_RST_EN];
	wire logic phase_sel = ctrl[`OCS_CTRL_PHASE];

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [1:0] rst_sync;
	logic [1:0] ref_sync;
	logic ref_last;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rst_sync <= 2'h0;
			ref_sync <= 2'h0;
			ref_last <= 1'b0;
		end else begin
			rst_sync <= {rst_sync[0], output_clock_reset};
			ref_sync <= {ref_sync[0], sync_reference_in};
			ref_last <= ref_sync[1];
		end
	end

	wire logic rst_act = rst_sync[1] && rst_on;
	wire logic ref_rise = ref_sync[1] && !ref_last;

	// ****************************************
	// Reset-pulse sequencer
	// ****************************************
	logic [3:0] count;
	logic [3:0] sync_dly;

	always_comb begin
		sync_dly = phase_sel ? `OCS_SYNC_DLY_90 : `OCS_SYNC_DLY_0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= OCS_RUN;
			count <= 4'h0;
		end else begin
			unique case (state)
				OCS_RUN: begin
					if (rst_act) begin
						state <= OCS_HOLD;
					end
				end
				OCS_HOLD: begin
					count <= 4'h1;
					if (!rst_sync[1]) begin
						state <= OCS_WAIT;
					end
				end
				OCS_WAIT: begin
					count <= count + 4'h1;
					if (rst_act) begin
						state <= OCS_HOLD;
					end else if (count == sync_dly) begin
						state <= OCS_RESUME;
						count <= 4'h0;
					end
				end
				OCS_RESUME: begin
					count <= count + 4'h1;
					if (count == `OCS_OUT_DLY) begin
						state <= OCS_RUN;
					end
				end
				default: begin
					state <= OCS_RUN;
				end
			endcase
		end
	end

	// First pulse after power-on arms the block; only armed exits realign
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			armed <= 1'b0;
			pulses <= 8'h00;
		end else if (state == OCS_WAIT && count == sync_dly && !rst_act) begin
			armed <= 1'b1;
			if (pulses != 8'hFF) begin
				pulses <= pulses + 8'h01;
			end
		end
	end

	// ****************************************
	// Divider and phase alignment
	// ****************************************
	logic [1:0] div;
	logic [1:0] ms_target;

	always_comb begin
		ms_target = `OCS_DIV_LAST;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div <= 2'h0;
			locked <= 1'b0;
		end else if (state == OCS_WAIT && count == sync_dly && !rst_act && armed) begin
			div <= 2'h0;
		end else if (ms_sync && is_slave && ref_rise) begin
			locked <= (div == ms_target);
			div <= 2'h0;
		end else begin
			div <= div + 2'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase <= 2'h0;
		end else begin
			phase <= div + tad;
		end
	end

	logic clk_div;
	logic clk_nd;
	logic raw_clk;
	logic delayed_clk;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_div <= 1'b1;
			clk_nd <= 1'b1;
		end else begin
			clk_div <= !phase[1];
			clk_nd <= !clk_nd;
		end
	end

	// Hold is applied before the pipeline so a partial cycle may slip out
	always_comb begin
		if (!demux) begin
			raw_clk = clk_nd;
		end else if (state == OCS_HOLD || state == OCS_WAIT || state == OCS_RESUME) begin
			raw_clk = 1'b1;
		end else begin
			raw_clk = clk_div;
		end
	end

	ocs_delay_line u_pipe (
		.hclk(hclk),
		.hresetn(hresetn),
		.din(raw_clk),
		.tap(`OCS_PIPE_LAT),
		.dout(delayed_clk)
	);

	// ****************************************
	// Outputs
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			i_channel_output_clock <= 1'b1;
			q_channel_output_clock <= 1'b1;
			sync_reference_out_a <= 1'b0;
			sync_reference_out_b <= 1'b0;
		end else begin
			i_channel_output_clock <= delayed_clk;
			q_channel_output_clock <= delayed_clk;
			sync_reference_out_a <= ms_sync && (div == 2'h0);
			sync_reference_out_b <= ms_sync && (div == 2'h0);
		end
	end
endmodule : ocs_output_clock_sync

/* ocs_peer_ref.sv */
// Purpose: Master reference clock model
// Assumes: Free running, one pulse in four cycles
// Notes: Phase set by bench
`timescale 1ns/1ps
module ocs_peer_ref (
	// Clock and phase
	input wire logic hclk,
	input wire logic [1:0] phase,
	// Reference
	output logic ref_clk
);
	logic [1:0] cnt = 2'h0;
	always_ff @(posedge hclk) cnt <= cnt + 2'h1;
	assign ref_clk = (cnt == phase);
endmodule : ocs_peer_ref

/* ocs_pkg.sv */
// Purpose: Types for output clock sync
// Assumes: Included map header provides constants
// Notes: None
package ocs_pkg;
	typedef enum logic [3:0] {
		OCS_RUN = 4'h1,
		OCS_HOLD = 4'h2,
		OCS_WAIT = 4'h4,
		OCS_RESUME = 4'h8
	} ocs_state_type;
endpackage : ocs_pkg

/* ocs_sync_props.sv */
// Purpose: Port assertions for output clock sync
// Assumes: Control word shadowed from bus writes
// Notes: Bound to top
`timescale 1ns/1ps
module ocs_sync_props
	import ocs_pkg::*;
(
	// Clock, reset, bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	// Sync
	input wire logic output_clock_reset,
	input wire logic i_channel_output_clock,
	input wire logic q_channel_output_clock,
	input wire logic sync_reference_out_a,
	input wire logic sync_reference_out_b
);
	logic wr_q;
	logic [7:0] ctrl;
	logic [3:0] quiet;
	logic [3:0] hi;
	logic oc, dmx, ms, ena;
	assign oc = i_channel_output_clock;
	assign dmx = ctrl[0];
	assign ms = ctrl[1];
	assign ena = ctrl[3] & ctrl[4];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			ctrl <= 8'h00;
			quiet <= 4'h0;
			hi <= 4'h0;
		end else begin
			if (hready)
				wr_q <= hsel & htrans[1] & hwrite & (haddr[7:0] == 8'h00);
			if (wr_q)
				ctrl <= hwdata[7:0];
			// Cycles since the control word was last written, covers the output pipeline
			if (wr_q)
				quiet <= 4'h0;
			else if (quiet != 4'hF)
				quiet <= quiet + 4'h1;
			// Cycles the reset pin has stood high
			if (!output_clock_reset)
				hi <= 4'h0;
			else if (hi != 4'hF)
				hi <= hi + 4'h1;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_iq; oc == q_channel_output_clock; endproperty
	a_iq: assert property (p_iq) else $error("I and Q clocks differ");
	property p_div; dmx && !ms && !ena && quiet >= 4'h9 && $changed(oc) |=> $stable(oc); endproperty
	a_div: assert property (p_div) else $error("demux clock too fast");
	property p_nd; !dmx && quiet >= 4'h9 |-> $changed(oc); endproperty
	a_nd: assert property (p_nd) else $error("plain clock stalled");
	property p_hold; dmx && ena && quiet >= 4'h9 && hi >= 4'hA |-> oc; endproperty
	a_hold: assert property (p_hold) else $error("clock not held high");
	property p_rel; dmx && ena && $fell(output_clock_reset) |-> ##[1:20] !oc; endproperty
	a_rel: assert property (p_rel) else $error("clock did not resume");
	property p_refab; sync_reference_out_a == sync_reference_out_b; endproperty
	a_refab: assert property (p_refab) else $error("reference outputs differ");
	property p_refoff; (!ms)[*2] |-> !sync_reference_out_a; endproperty
	a_refoff: assert property (p_refoff) else $error("reference while sync off");
	property p_ref4; sync_reference_out_a && !ctrl[2] ##1 !ctrl[2] |-> !sync_reference_out_a [*3]; endproperty
	a_ref4: assert property (p_ref4) else $error("reference pacing wrong");
	c_hold: cover property ((dmx && ena && output_clock_reset)[*8]);
	c_ref: cover property (sync_reference_out_a && ctrl[2]);
	c_rel: cover property (ena && $fell(output_clock_reset));
endmodule : ocs_sync_props
bind ocs_output_clock_sync ocs_sync_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .output_clock_reset, .i_channel_output_clock, .q_channel_output_clock, .sync_reference_out_a,
	.sync_reference_out_b);

/* ocs_testbench.sv */
// Purpose: Self-checking bench for output clock sync
// Assumes: One slave, hready taken from hreadyout
// Notes: Clock phases compared against each other
`timescale 1ns/1ps
`include "ocs_map.svh"
module testbench;
	logic hclk = 1'b0;
	logic hresetn, hsel, hwrite, hreadyout, hresp, output_clock_reset, sync_reference_in;
	logic i_channel_output_clock, q_channel_output_clock, sync_reference_out_a, sync_reference_out_b;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, ph;
	logic [2:0] hsize;
	int mismatches = 0;
	int checked = 0;
	always #12.5 hclk = ~hclk;
	ocs_output_clock_sync DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .output_clock_reset, .sync_reference_in,
		.i_channel_output_clock, .q_channel_output_clock, .sync_reference_out_a, .sync_reference_out_b);
	ocs_peer_ref PEER (.hclk, .phase(ph), .ref_clk(sync_reference_in));
	task automatic complete_run;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	task automatic lim(input int k, input int m);
		if (k >= m) begin
			mismatches++;
			complete_run;
		end
	endtask : lim
	task automatic wt;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		lim(n, 64);
	endtask : wt
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] exp,
		input logic [31:0] msk = 32'hFFFF_FFFF);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wt;
		htrans <= 2'h0;
		hwdata <= d;
		wt;
		chk(hresp, 32'h0);
		if (!w)
			chk(hrdata & msk, exp);
	endtask : bus
	task automatic wait_low(output int k);
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (i_channel_output_clock !== 1'b0 && k < 40);
		lim(k, 40);
	endtask : wait_low
	task automatic rises(input int n, output int r);
		logic p;
		r = 0;
		p = i_channel_output_clock;
		repeat (n) begin
			@(posedge hclk);
			r += (p === 1'b0 && i_channel_output_clock === 1'b1) ? 1 : 0;
			p = i_channel_output_clock;
			chk(q_channel_output_clock, i_channel_output_clock);
		end
	endtask : rises
	task automatic pulse(output int k);
		output_clock_reset <= 1'b1;
		repeat (12) @(posedge hclk);
		chk(i_channel_output_clock, 32'h1);
		output_clock_reset <= 1'b0;
		wait_low(k);
	endtask : pulse
	task automatic t_regs;
		bus(1'b0, `OCS_ADDR_CTRL, 32'h0, 32'h0);
		bus(1'b1, `OCS_ADDR_TAD, 32'h3, 32'h0);
		bus(1'b0, `OCS_ADDR_TAD, 32'h0, 32'h3);
		bus(1'b0, 32'h40, 32'h0, 32'h0);
	endtask : t_regs
	task automatic t_clocks;
		int r;
		rises(8, r);
		chk(r, 4);
		bus(1'b1, `OCS_ADDR_CTRL, 32'h1, 32'h0);
		repeat (8) @(posedge hclk);
		rises(16, r);
		chk(r, 4);
		output_clock_reset <= 1'b1;
		rises(16, r);
		chk(r, 4);
		output_clock_reset <= 1'b0;
	endtask : t_clocks
	task automatic t_pulse;
		int k, k1, k0;
		bus(1'b1, `OCS_ADDR_CTRL, 32'h39, 32'h0);
		pulse(k);
		pulse(k1);
		bus(1'b1, `OCS_ADDR_CTRL, 32'h19, 32'h0);
		pulse(k0);
		chk(k0, k1 + 1);
		pulse(k);
		chk(k, k0);
	endtask : t_pulse
	task automatic t_sync;
		logic [3:0] pat [2];
		int k;
		bus(1'b1, `OCS_ADDR_CTRL, 32'h3, 32'h0);
		@(posedge hclk);
		k = 0;
		repeat (16) begin
			@(posedge hclk);
			k += (sync_reference_out_a === 1'b1) ? 1 : 0;
			chk(sync_reference_out_b, sync_reference_out_a);
		end
		chk(k, 4);
		bus(1'b1, `OCS_ADDR_CTRL, 32'h7, 32'h0);
		for (int p = 0; p < 2; p++) begin
			ph <= (p == 1) ? 2'h2 : 2'h0;
			repeat (16) @(posedge hclk);
			k = 0;
			do begin
				@(posedge hclk);
				k++;
			end while (sync_reference_in !== 1'b1 && k < 8);
			lim(k, 8);
			for (int b = 0; b < 4; b++) begin
				@(posedge hclk);
				pat[p][b] = i_channel_output_clock;
			end
		end
		chk(pat[1], pat[0]);
		bus(1'b0, `OCS_ADDR_STATUS, 32'h0, 32'h0000_0418, 32'h0000_FF1C);
	endtask : t_sync
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		output_clock_reset = 1'b0;
		ph = 2'h0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs;
		t_clocks;
		t_pulse;
		t_sync;
		complete_run;
	end
endmodule : testbench
